// ---- hdl/asp_port.sv ----
// Purpose: serial host port with ready pin, framing, check words and timeout
// Assumes: serial pins are asynchronous to pclk and toggle slower than pclk/6
// Notes: command decoding lives outside; it answers through resp_word
`timescale 1ns/1ps
`default_nettype none

module asp_port
  import asp_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_MCLK
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic conversion_ready_n,
  output logic conversion_ready_n_oe,
  // converter side
  input wire logic conv_done,
  input wire logic [1:0] ch_en,
  input wire logic [23:0] ch0_data,
  input wire logic [23:0] ch1_data,
  // command decoder side
  output logic [15:0] cmd_word,
  output logic cmd_stb,
  output logic reset_cmd,
  input wire logic [15:0] resp_word,
  input wire logic resp_status,
  output logic [15:0] rx_word,
  output logic [2:0] rx_word_idx,
  output logic rx_word_stb,
  output logic [2:0] tx_word_idx,
  input wire logic [15:0] ext_tx_word
);

  asp_mode_t mode_q;
  logic [31:0] prdata_q;
  asp_spi_in_t s1_q, s2_q, s3_q;
  logic sclk_rise, sclk_fall, cs_rise, ser_clr, to_fire, active_q;
  logic [15:0] to_cnt_q;
  logic [5:0] bit_cnt_q;
  logic [2:0] word_cnt_q;
  logic word_end, bit_out, reading, data_read;
  logic [31:0] rx_sh_q, rx_nxt, tx_sh_q, tx_word;
  logic [15:0] in_crc_q, out_crc_q, cmd_q, resp_q, status16, poly;
  logic crc_match_q, dout_q, dout_oe_q, resp_stat_q, crc_err_q;
  logic frame_end, crc_bad, exec, cmd_stb_q, reset_q;
  logic [1:0] ch_rdy_q;
  logic [23:0] ch0_q, ch1_q;
  asp_rdy_state_t rdy_st_q;
  logic [3:0] rdy_cnt_q;
  logic ready_n_q;
  logic [15:0] rx_word_q;
  logic [2:0] rx_idx_q;
  logic rx_stb_q;

  // ---------------- apb: zero wait, read data captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & (paddr != REG_MODE) & (paddr != REG_STATUS) &
                   (paddr != REG_CH0) & (paddr != REG_CH1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
    end else if (psel && penable && pwrite && paddr == REG_MODE) begin
      mode_q <= pwdata[MODE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        REG_MODE: prdata_q <= {26'h000_0000, mode_q};
        REG_STATUS: prdata_q <= {16'h0000, status16};
        REG_CH0: prdata_q <= {8'h00, ch0_q};
        REG_CH1: prdata_q <= {8'h00, ch1_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------- pin synchronisers; s1 feeds s2 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= SPI_IDLE;
      s2_q <= SPI_IDLE;
      s3_q <= SPI_IDLE;
    end else begin
      s1_q <= '{cs_n: cs_n, sclk: sclk, din: din};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign sclk_rise = s2_q.sclk & ~s3_q.sclk & ~s2_q.cs_n;
  assign sclk_fall = ~s2_q.sclk & s3_q.sclk & ~s2_q.cs_n;
  assign cs_rise = s2_q.cs_n & ~s3_q.cs_n;
  assign poly = mode_q.crc_ansi ? POLY_ANSI : POLY_CCITT;

  // ---------------- frame timeout, measured from the first serial edge
  assign to_fire = mode_q.to_en & active_q & (to_cnt_q == 16'(TIMEOUT_CYCLES - 1));
  assign ser_clr = s2_q.cs_n | to_fire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
      to_cnt_q <= 16'h0000;
    end else if (ser_clr) begin
      active_q <= 1'b0;
      to_cnt_q <= 16'h0000;
    end else begin
      if (sclk_rise || sclk_fall) begin
        active_q <= 1'b1;
      end
      if (active_q) begin
        to_cnt_q <= to_cnt_q + 16'h0001;
      end
    end
  end

  // ---------------- receive path, captured on falling serial edges
  assign rx_nxt = {rx_sh_q[30:0], s2_q.din};
  assign word_end = sclk_fall & (bit_cnt_q == word_bits(mode_q.word_size_select) - 6'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_q <= 6'h00;
      word_cnt_q <= 3'h0;
      rx_sh_q <= 32'h0000_0000;
      in_crc_q <= CRC_SEED;
      crc_match_q <= 1'b0;
    end else if (ser_clr) begin
      bit_cnt_q <= 6'h00;
      word_cnt_q <= 3'h0;
      in_crc_q <= CRC_SEED;
      crc_match_q <= 1'b0;
    end else if (sclk_fall) begin
      rx_sh_q <= rx_nxt;
      if (word_cnt_q == WORD_RESP) begin
        in_crc_q <= crc_step(in_crc_q, s2_q.din, poly);
      end
      if (word_end) begin
        bit_cnt_q <= 6'h00;
        if (word_cnt_q != WORD_LAST) begin
          word_cnt_q <= word_cnt_q + 3'h1;
        end
        if (word_cnt_q == WORD_CH0) begin
          crc_match_q <= (top16(rx_nxt, mode_q.word_size_select) == in_crc_q);
        end
      end else begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  // the command stays put after the frame so the decoder can answer it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 16'h0000;
      rx_word_q <= 16'h0000;
      rx_idx_q <= 3'h0;
      rx_stb_q <= 1'b0;
    end else begin
      rx_stb_q <= word_end & ~ser_clr;
      if (word_end && !ser_clr) begin
        rx_word_q <= top16(rx_nxt, mode_q.word_size_select);
        rx_idx_q <= word_cnt_q;
        if (word_cnt_q == WORD_RESP) begin
          cmd_q <= top16(rx_nxt, mode_q.word_size_select);
        end
      end
    end
  end

  // ---------------- transmit path, launched on rising serial edges
  always_comb begin
    status16 = 16'h0000;
    status16[STAT_CRCERR_BIT] = crc_err_q;
    status16[STAT_RDY_LSB+:2] = ch_rdy_q;
    case (word_cnt_q)
      WORD_RESP: tx_word = {resp_stat_q ? status16 : resp_q, 16'h0000};
      WORD_CH0: tx_word = fmt_data(ch0_q, mode_q.word_size_select);
      WORD_CH1: tx_word = fmt_data(ch1_q, mode_q.word_size_select);
      WORD_CRC: tx_word = {out_crc_q, 16'h0000};
      default: tx_word = {ext_tx_word, 16'h0000};
    endcase
  end

  assign bit_out = (bit_cnt_q == 6'h00) ? tx_word[31] : tx_sh_q[31];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_q <= 32'h0000_0000;
      dout_q <= 1'b0;
      out_crc_q <= CRC_SEED;
    end else if (ser_clr) begin
      dout_q <= 1'b0;
      out_crc_q <= CRC_SEED;
    end else if (sclk_rise) begin
      dout_q <= bit_out;
      tx_sh_q <= (bit_cnt_q == 6'h00) ? {tx_word[30:0], 1'b0} : {tx_sh_q[30:0], 1'b0};
      if (word_cnt_q < WORD_CRC) begin
        out_crc_q <= crc_step(out_crc_q, bit_out, poly);
      end
    end
  end

  // oe follows the synchronised select, so it lags the pin by three clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_oe_q <= 1'b0;
    end else begin
      dout_oe_q <= ~s2_q.cs_n;
    end
  end

  assign dout = dout_q;
  assign dout_oe = dout_oe_q;
  assign tx_word_idx = word_cnt_q;

  // ---------------- end of frame: check, execute, pick next response
  assign frame_end = cs_rise & (word_cnt_q != WORD_RESP);
  assign crc_bad = mode_q.rx_crc_en & ((word_cnt_q < WORD_CH1) | ~crc_match_q);
  assign exec = (~crc_bad | (cmd_q[15:13] == OP_REG_WRITE)) &
                ~((cmd_q == CMD_RESET) & (word_cnt_q < WORDS_FULL));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_stb_q <= 1'b0;
      reset_q <= 1'b0;
      resp_q <= 16'h0000;
      resp_stat_q <= 1'b1;
    end else begin
      cmd_stb_q <= frame_end & exec;
      reset_q <= frame_end & exec & (cmd_q == CMD_RESET);
      if (frame_end) begin
        resp_q <= resp_word;
        resp_stat_q <= crc_bad | resp_status;
      end
    end
  end

  assign cmd_word = cmd_q;
  assign cmd_stb = cmd_stb_q;
  assign reset_cmd = reset_q;
  assign rx_word = rx_word_q;
  assign rx_word_idx = rx_idx_q;
  assign rx_word_stb = rx_stb_q;

  // ---------------- status flags; a set in the clearing cycle wins
  assign data_read = word_end & ~ser_clr & (word_cnt_q == WORD_CH1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_err_q <= 1'b0;
      ch_rdy_q <= 2'h0;
      ch0_q <= 24'h00_0000;
      ch1_q <= 24'h00_0000;
    end else begin
      crc_err_q <= (frame_end & crc_bad) |
                   (crc_err_q & ~(word_end & ~ser_clr & (word_cnt_q == WORD_RESP) & resp_stat_q));
      ch_rdy_q[0] <= (conv_done & ch_en[0]) |
                     (ch_rdy_q[0] & ~(word_end & ~ser_clr & (word_cnt_q == WORD_CH0)));
      ch_rdy_q[1] <= (conv_done & ch_en[1]) | (ch_rdy_q[1] & ~data_read);
      if (conv_done) begin
        ch0_q <= ch0_data;
        ch1_q <= ch1_data;
      end
    end
  end

  // ---------------- ready pin
  // the early high pulse delays the falling edge by its width instead of
  // predicting the next completion; the result is the same edge spacing
  assign reading = ~s2_q.cs_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_st_q <= RS_HIGH;
      rdy_cnt_q <= 4'h0;
      ready_n_q <= 1'b1;
    end else begin
      case (rdy_st_q)
        RS_HIGH: begin
          if (conv_done) begin
            rdy_st_q <= RS_LOW;
            ready_n_q <= 1'b0;
          end
        end
        RS_LOW: begin
          if (conv_done && !reading) begin
            rdy_st_q <= RS_PULSE;
            rdy_cnt_q <= 4'(DRH_CYC - 1);
            ready_n_q <= 1'b1;
          end else if (conv_done) begin
            ready_n_q <= 1'b0;
          end else if (data_read) begin
            rdy_st_q <= RS_HIGH;
            ready_n_q <= 1'b1;
          end
        end
        RS_PULSE: begin
          if (rdy_cnt_q == 4'h0) begin
            rdy_st_q <= RS_LOW;
            ready_n_q <= 1'b0;
          end else begin
            rdy_cnt_q <= rdy_cnt_q - 4'h1;
          end
        end
        default: begin
          rdy_st_q <= RS_HIGH;
          ready_n_q <= 1'b1;
        end
      endcase
    end
  end

  assign conversion_ready_n = mode_q.ready_pin_open_drain ? 1'b0 : ready_n_q;
  assign conversion_ready_n_oe = mode_q.ready_pin_open_drain ? ~ready_n_q : 1'b1;

  // ---------------- checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_unread_done;
    rdy_st_q == RS_LOW && conv_done && !reading;
  endsequence

  sequence s_pulse_then_fall;
    ready_n_q [*4] ##1 !ready_n_q;
  endsequence

  a_ready_falls_done: assert property (rdy_st_q == RS_HIGH && conv_done |=> !ready_n_q)
    else $error("ready did not fall on new results");
  a_ready_rises_read: assert property (
    rdy_st_q == RS_LOW && !conv_done && data_read |=> ready_n_q && rdy_st_q == RS_HIGH)
    else $error("ready did not rise after both channels read");
  a_ready_holds_partial: assert property (
    rdy_st_q == RS_LOW && !conv_done && !data_read |=> !ready_n_q)
    else $error("ready rose without a complete read");
  a_pulse_width_exact: assert property (s_unread_done |=> s_pulse_then_fall)
    else $error("ready high pulse has the wrong width");
  a_pulse_blocked_read: assert property (
    rdy_st_q == RS_LOW && conv_done && reading |=> !ready_n_q [*2])
    else $error("ready pulsed during a readout");
  a_open_drain_release: assert property (
    mode_q.ready_pin_open_drain |-> !conversion_ready_n && (conversion_ready_n_oe == !ready_n_q))
    else $error("open drain ready pin driven high");
  a_dout_float_cs: assert property (s2_q.cs_n |=> !dout_oe && bit_cnt_q == 6'h00)
    else $error("data output driven or counters live with select high");
  a_crc_err_flag: assert property (frame_end && crc_bad |=> crc_err_q && resp_stat_q)
    else $error("check error not flagged");
  a_reset_full_frame: assert property (
    reset_cmd |-> $past(word_cnt_q) >= WORDS_FULL && $past(cs_rise))
    else $error("reset issued from a short frame");
  a_timeout_clears: assert property (
    to_fire && !s2_q.cs_n |=> word_cnt_q == 3'h0 && bit_cnt_q == 6'h00 && !active_q)
    else $error("timeout did not reset the serial logic");
  a_seed_at_start: assert property (
    $rose(s2_q.cs_n) |=> in_crc_q == CRC_SEED && out_crc_q == CRC_SEED)
    else $error("check words not reseeded");

endmodule : asp_port

`default_nettype wire

// ---- hdl/asp_pkg.sv ----
// Purpose: shared constants, types and helpers of the converter serial host port
// Assumes: pclk is the device main clock at 250 MHz; APB register access
// Notes: word payloads are kept left aligned in 32 bits until shifted out
`default_nettype none

package asp_pkg;

  localparam int CLK_NS = 4;

  // apb map, byte addresses
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CH0 = 8'h08;
  localparam logic [7:0] REG_CH1 = 8'h0C;

  // word size codes
  localparam logic [1:0] WSEL_16 = 2'h0;
  localparam logic [1:0] WSEL_24 = 2'h1;
  localparam logic [1:0] WSEL_32Z = 2'h2;
  localparam logic [1:0] WSEL_32S = 2'h3;

  // mode register, bit 0 upward: word_size_select, open drain, rx check, poly, timeout
  typedef struct packed {
    logic to_en;
    logic crc_ansi;
    logic rx_crc_en;
    logic ready_pin_open_drain;
    logic [1:0] word_size_select;
  } asp_mode_t;
  localparam int MODE_W = 6;
  localparam asp_mode_t MODE_RST = '{to_en: 1'b1, crc_ansi: 1'b0, rx_crc_en: 1'b0,
                                     ready_pin_open_drain: 1'b0, word_size_select: WSEL_24};

  // status word fields
  localparam int STAT_CRCERR_BIT = 12;
  localparam int STAT_RDY_LSB = 0;

  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] POLY_ANSI = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [2:0] OP_REG_WRITE = 3'h3;

  // frame word positions
  localparam logic [2:0] WORD_RESP = 3'h0;
  localparam logic [2:0] WORD_CH0 = 3'h1;
  localparam logic [2:0] WORD_CH1 = 3'h2;
  localparam logic [2:0] WORD_CRC = 3'h3;
  localparam logic [2:0] WORDS_FULL = 3'h4;
  localparam logic [2:0] WORD_LAST = 3'h7;

  // timing
  localparam int TIMEOUT_MCLK = 2 ** 15;
  localparam int DRH_NS = 16;
  localparam int DRH_CYC = (DRH_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } asp_spi_in_t;
  localparam asp_spi_in_t SPI_IDLE = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};

  typedef enum logic [2:0] {
    RS_HIGH = 3'b001,
    RS_LOW = 3'b010,
    RS_PULSE = 3'b100
  } asp_rdy_state_t;

  function automatic logic [15:0] crc_step(logic [15:0] c, logic b, logic [15:0] poly);
    logic fb;
    fb = c[15] ^ b;
    return {c[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
  endfunction : crc_step

  function automatic logic [5:0] word_bits(logic [1:0] ws);
    case (ws)
      WSEL_16: return 6'h10;
      WSEL_24: return 6'h18;
      default: return 6'h20;
    endcase
  endfunction : word_bits

  function automatic logic [31:0] fmt_data(logic [23:0] d, logic [1:0] ws);
    case (ws)
      WSEL_16: return {d[23:8], 16'h0000};
      WSEL_32S: return {{8{d[23]}}, d};
      default: return {d, 8'h00};
    endcase
  endfunction : fmt_data

  // top 16 bits of a word received right aligned in a 32 bit shifter
  function automatic logic [15:0] top16(logic [31:0] w, logic [1:0] ws);
    case (ws)
      WSEL_16: return w[15:0];
      WSEL_24: return w[23:8];
      default: return w[31:16];
    endcase
  endfunction : top16

endpackage : asp_pkg

`default_nettype wire

// ---- testbench/asp_host_model.sv ----
// Purpose: behavioural spi host that frames words towards the serial port
// Assumes: mode 1 link, sclk half period of four pclk (32 ns period)
// Notes: sclk stands low outside frames; din flips while deselected
`timescale 1ns/1ps
`default_nettype none

module asp_host_model (
  // clock
  input wire logic pclk,
  // link
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  // select or release; the gap keeps cs high long enough for the sync stages
  task automatic sel(input logic on);
    @(posedge pclk);
    cs_n <= ~on;
    if (!on) din <= ~din; // no stale bit left on a released line
    repeat (8) @(posedge pclk);
  endtask : sel

  // msb first: new bit on the rise, dout taken well after the fall
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0000_0000;
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b1;
      din <= tx[i];
      repeat (4) @(posedge pclk);
      sclk <= 1'b0;
      repeat (4) @(posedge pclk);
      rx = {rx[30:0], dout};
    end
  endtask : shift
endmodule : asp_host_model

`default_nettype wire

// ---- testbench/asp_port_tb.sv ----
// Purpose: self-checking bench for the converter serial host port
// Assumes: timeout shortened to 2048 pclk so full frames still fit
// Notes: decoder answers with a fixed word; stimulus only at rising edges
`timescale 1ns/1ps
`default_nettype none

module asp_port_tb;
  import asp_pkg::*;
  localparam int TO_CYC = 2048;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, cs_n, sclk, din, dout, dout_oe, conversion_ready_n, rdy_oe;
  logic conv_done = 1'b0;
  logic [1:0] ch_en = 2'h3;
  logic [23:0] ch0_data = 24'h000000;
  logic [23:0] ch1_data = 24'h000000;
  logic [15:0] resp_word = 16'hA5C3;
  logic [15:0] ext_tx_word = 16'h0000;
  logic resp_status = 1'b0;
  logic [15:0] cmd_word, rx_word;
  logic cmd_stb, reset_cmd, rx_word_stb;
  logic [2:0] rx_word_idx, tx_word_idx;
  logic [31:0] rw [5];
  logic [1:0] ws = WSEL_24;
  logic [15:0] poly = POLY_CCITT;
  int wb = 24;
  int err_count = 0;
  int cmp_count = 0;
  int n_cmd = 0;
  int n_rst = 0;
  int n_rxw = 0;
  wire ready_pin;
  wire miso;
  // pull-up on the ready line; a floating dout shows the inverse level
  assign ready_pin = rdy_oe ? conversion_ready_n : 1'b1;
  assign miso = dout_oe ? dout : ~dout;

  always #2 pclk = ~pclk;

  asp_port #(.TIMEOUT_CYCLES(TO_CYC)) i_asp_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .conversion_ready_n(conversion_ready_n), .conversion_ready_n_oe(rdy_oe),
    .conv_done(conv_done), .ch_en(ch_en), .ch0_data(ch0_data), .ch1_data(ch1_data),
    .cmd_word(cmd_word), .cmd_stb(cmd_stb), .reset_cmd(reset_cmd),
    .resp_word(resp_word), .resp_status(resp_status), .rx_word(rx_word),
    .rx_word_idx(rx_word_idx), .rx_word_stb(rx_word_stb), .tx_word_idx(tx_word_idx),
    .ext_tx_word(ext_tx_word)
  );

  asp_host_model i_asp_host_model (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(miso));

  always @(posedge pclk) begin
    if (cmd_stb === 1'b1) n_cmd++;
    if (reset_cmd === 1'b1) n_rst++;
    if (rx_word_stb === 1'b1) n_rxw++;
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check("apb answer", 32'h0, 32'h1);
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic set_mode(input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(1'b1, REG_MODE, m, q, e);
    apb(1'b0, REG_MODE, 32'h0, q, e);
    check("mode readback", q, m);
    ws = m[1:0];
    poly = m[4] ? 16'h8005 : 16'h1021;
    wb = (ws == WSEL_16) ? 16 : (ws == WSEL_24) ? 24 : 32;
  endtask : set_mode

  function automatic logic [31:0] w16(logic [15:0] v);
    return {16'h0000, v} << (wb - 16);
  endfunction : w16

  function automatic logic [31:0] fmt(logic [23:0] d);
    case (ws)
      WSEL_16: return {16'h0000, d[23:8]};
      WSEL_24: return {8'h00, d};
      WSEL_32Z: return {d, 8'h00};
      default: return {{8{d[23]}}, d};
    endcase
  endfunction : fmt

  function automatic logic [15:0] crc(logic [15:0] c, logic [31:0] w);
    for (int i = wb - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? poly : 16'h0);
    return c;
  endfunction : crc

  task automatic frame(input logic [31:0] c0, input logic [31:0] c1, input int nw);
    i_asp_host_model.sel(1'b1);
    check("dout driven", dout_oe, 1'b1);
    for (int k = 0; k < nw; k++) begin
      i_asp_host_model.shift((k == 0) ? c0 : (k == 1) ? c1 : 32'h0, wb, rw[k]);
    end
    i_asp_host_model.sel(1'b0);
    check("dout released", dout_oe, 1'b0);
  endtask : frame

  task automatic conv(input logic [23:0] a, input logic [23:0] b);
    ch0_data <= a;
    ch1_data <= b;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    // return mid-cycle so the first cycle of a ready pulse is seen
    @(negedge pclk);
  endtask : conv

  task automatic high_cycles(output int n);
    n = 0;
    repeat (20) begin
      if (ready_pin === 1'b1) n++;
      @(negedge pclk);
    end
  endtask : high_cycles

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    check("idle pins", {rdy_oe, ready_pin, dout_oe}, 32'h6);
    apb(1'b0, REG_MODE, 32'h0, q, e);
    check("mode reset", q, 32'h21);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check("unmapped", e, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_ready();
    int n;
    logic [31:0] q;
    logic e;
    conv(24'h123456, 24'h89ABCD);
    check("ready fall", ready_pin, 1'b0);
    frame(32'h0, 32'h0, 4);
    check("ch0 at fall", rw[1], fmt(24'h123456));
    check("ready rise", ready_pin, 1'b1);
    apb(1'b0, REG_CH1, 32'h0, q, e);
    check("ch1 register", q, 32'h0089ABCD);
    conv(24'h000001, 24'h000002);
    frame(32'h0, 32'h0, 2);
    check("resp word", rw[0], w16(16'hA5C3));
    check("partial read", ready_pin, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    check("ch1 still unread", q, 32'h2);
    conv(24'h000003, 24'h000004);
    high_cycles(n);
    check("unread pulse", n, DRH_CYC);
    check("ready after pulse", ready_pin, 1'b0);
    fork
      frame(32'h0, 32'h0, 4);
      begin
        repeat (60) @(posedge pclk);
        conv(24'h000005, 24'h000006);
        high_cycles(n);
        check("pulse blocked", n, 0);
      end
    join
    check("ready after full", ready_pin, 1'b1);
    $display("test ready done");
  endtask : t_ready

  task automatic t_sizes();
    logic [1:0] tbl [4] = '{WSEL_16, WSEL_32Z, WSEL_32S, WSEL_24};
    logic [15:0] c;
    for (int i = 0; i < 4; i++) begin
      set_mode({26'h0, 1'b1, i < 2, 2'b00, tbl[i]});
      conv(24'h80A5C3, 24'h123456);
      frame(32'h0, 32'h0, 4);
      check("resp", rw[0], w16(16'hA5C3));
      check("ch0", rw[1], fmt(24'h80A5C3));
      check("ch1", rw[2], fmt(24'h123456));
      c = crc(crc(crc(16'hFFFF, w16(16'hA5C3)), fmt(24'h80A5C3)), fmt(24'h123456));
      check("out crc", rw[3], w16(c));
    end
    $display("test sizes done");
  endtask : t_sizes

  task automatic t_open_drain();
    set_mode(32'h25);
    check("od idle", {rdy_oe, conversion_ready_n}, 32'h0);
    conv(24'h000007, 24'h000008);
    check("od asserted", {rdy_oe, conversion_ready_n}, 32'h2);
    frame(32'h0, 32'h0, 4);
    check("od released", ready_pin, 1'b1);
    set_mode(32'h21);
    $display("test open drain done");
  endtask : t_open_drain

  task automatic t_crc_in();
    int n;
    set_mode(32'h29);
    n = n_cmd;
    frame(w16(16'h1234), w16(~crc(16'hFFFF, w16(16'h1234))), 4);
    check("bad crc dropped", n_cmd - n, 0);
    resp_status <= 1'b1;
    frame(32'h0, w16(crc(16'hFFFF, 32'h0)), 4);
    check("crc flag", rw[0][12 + 8], 1'b1);
    check("good cmd runs", n_cmd - n, 1);
    frame(w16(16'h6000), w16(~crc(16'hFFFF, w16(16'h6000))), 4);
    check("flag cleared", rw[0][12 + 8], 1'b0);
    check("status resp", rw[0], 32'h0);
    check("write runs", n_cmd - n, 2);
    resp_status <= 1'b0;
    set_mode(32'h21);
    $display("test input crc done");
  endtask : t_crc_in

  task automatic t_long();
    int n = n_rxw;
    ext_tx_word <= 16'h5A3C;
    frame(w16(16'h2345), 32'h0, 5);
    check("ext word", rw[4], w16(16'h5A3C));
    check("rx words", n_rxw - n, 5);
    check("rx last idx", rx_word_idx, 3'h4);
    check("rx last word", rx_word, 32'h0);
    check("cmd kept", cmd_word, 32'h2345);
    check("out idx idle", tx_word_idx, 3'h0);
    ext_tx_word <= 16'h0000;
    $display("test long frame done");
  endtask : t_long

  task automatic t_short_and_timeout();
    logic [31:0] q;
    int n = n_rst;
    ch_en <= 2'h0;
    frame(w16(16'h0011), 32'h0, 2);
    check("short reset ignored", n_rst - n, 0);
    frame(w16(16'h0011), 32'h0, 4);
    check("full reset runs", n_rst - n, 1);
    ch_en <= 2'h3;
    i_asp_host_model.sel(1'b1);
    i_asp_host_model.shift(32'hFF, 8, q);
    repeat (TO_CYC + 60) @(posedge pclk);
    for (int k = 0; k < 4; k++) i_asp_host_model.shift((k == 0) ? w16(16'h0011) : 32'h0, wb, q);
    i_asp_host_model.sel(1'b0);
    check("timeout realigns", n_rst - n, 2);
    $display("test short and timeout done");
  endtask : t_short_and_timeout

  initial begin
    repeat (90000) @(posedge pclk);
    err_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset();
    t_ready();
    t_sizes();
    t_open_drain();
    t_crc_in();
    t_long();
    t_short_and_timeout();
    results();
  end
endmodule : asp_port_tb

`default_nettype wire
